/* hdl/dac_serial_control.sv */
// Digital control of a single-channel voltage-output converter
`timescale 1ns/1ps
`include "dac_defs.svh"

module dac_serial_control
    import dac_pkg::*;
#(
    parameter int RES_BITS = 16,
    parameter bit ZERO_SCALE_VARIANT = 1'b1,
    parameter int POR_DELAY_CYCLES = `POR_DELAY_CYCLES,
    // Arbitrary upper address bits; bit 0 comes from the address select pin
    parameter logic [6:0] I2C_ADDR_BASE = 7'h4a
)
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_interface_select_pin,
    input wire logic i_sclk,
    input wire logic i_serial_data_in,
    // Doubles as address_select_pin in I2C mode
    input wire logic i_frame_select_n,
    input wire logic i_reference_overrange,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic [RES_BITS-1:0] o_output_code,
    output logic o_output_power_down,
    output logic o_reference_power_down,
    output logic o_reference_halve,
    output logic o_output_gain_double,
    output logic o_reference_alarm,
    output logic o_ready
);
    localparam int POR_CNT_W = $clog2(POR_DELAY_CYCLES + 1);
    localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_DELAY_CYCLES);
    localparam logic [RES_BITS-1:0] CODE_RESET =
        ZERO_SCALE_VARIANT ? '0 : {1'b1, {(RES_BITS-1){1'b0}}};

    iface_type iface_mode;
    logic mode_captured;
    logic [POR_CNT_W-1:0] por_count;
    logic soft_reset_req;

    logic deferred_update_enable;
    logic [RES_BITS-1:0] buffer_code;

    logic spi_valid;
    logic [23:0] spi_frame;

    i2c_state_type i2c_state;
    logic scl_d;
    logic sda_d;
    logic [2:0] bit_count;
    logic [7:0] rx_byte;
    logic [1:0] byte_index;
    logic is_read;
    logic general_call;
    logic ack_phase;
    logic master_ack;
    logic [7:0] reg_pointer;
    logic [7:0] data_high_byte;
    logic [15:0] tx_word;
    logic i2c_wr_valid;
    logic [15:0] i2c_wr_data;
    logic i2c_gc_reset;

    logic wr_valid;
    logic [7:0] wr_addr;
    reg_word_type wr_data;
    logic scl_rise;
    logic scl_fall;
    logic i2c_start;
    logic i2c_stop;
    logic i2c_active;
    reg_word_type read_word;

    function automatic reg_word_type read_reg(input logic [7:0] addr);
        reg_word_type value;
        value = 16'h0000;
        case (addr)
            `REG_UPDATE_MODE:
                value[`BIT_DEFERRED_UPDATE_ENABLE] = deferred_update_enable;
            `REG_POWER_DOWN_CONFIG:
            begin
                value[`BIT_OUTPUT_POWER_DOWN] = o_output_power_down;
                value[`BIT_REFERENCE_POWER_DOWN] = o_reference_power_down;
            end
            `REG_REFERENCE_AND_GAIN:
            begin
                value[`BIT_REFERENCE_HALVE] = o_reference_halve;
                value[`BIT_OUTPUT_GAIN_DOUBLE] = o_output_gain_double;
            end
            `REG_OUTPUT_CODE:
                value = 16'(buffer_code);
            default:
                value = 16'h0000;
        endcase
        return value;
    endfunction

    always_comb read_word = read_reg(reg_pointer);

    // Interface chosen once; a later level change is not followed
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            mode_captured <= 1'b0;
            iface_mode <= IF_SPI;
        end
        else if (!mode_captured)
        begin
            mode_captured <= 1'b1;
            iface_mode <= i_interface_select_pin ? IF_I2C : IF_SPI;
        end
    end

    // Software reset restarts the same delay as power-on
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            por_count <= '0;
            o_ready <= 1'b0;
        end
        else
        begin
            if (soft_reset_req)
                por_count <= '0;
            else if (por_count != POR_LAST)
                por_count <= por_count + 1'b1;
            o_ready <= mode_captured && por_count == POR_LAST && !soft_reset_req;
        end
    end

    spi_frame_receiver u_spi_frame_receiver (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_enable(o_ready && iface_mode == IF_SPI),
        .i_sclk(i_sclk),
        .i_serial_data_in(i_serial_data_in),
        .i_frame_select_n(i_frame_select_n),
        .o_frame_valid(spi_valid),
        .o_frame_data(spi_frame)
    );

    assign scl_rise = !scl_d && i_sclk;
    assign scl_fall = scl_d && !i_sclk;
    assign i2c_start = scl_d && i_sclk && sda_d && !i_serial_data_in;
    assign i2c_stop = scl_d && i_sclk && !sda_d && i_serial_data_in;
    assign i2c_active = o_ready && iface_mode == IF_I2C;
    assign o_sda_out = 1'b0;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= i_sclk;
            sda_d <= i_serial_data_in;
        end
    end

    // I2C slave: bits sampled on SCL rise, SDA driven after SCL fall
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            i2c_state <= I2C_IDLE;
            bit_count <= 3'h0;
            rx_byte <= 8'h00;
            byte_index <= 2'h0;
            is_read <= 1'b0;
            general_call <= 1'b0;
            ack_phase <= 1'b0;
            master_ack <= 1'b0;
            reg_pointer <= 8'h00;
            data_high_byte <= 8'h00;
            tx_word <= 16'h0000;
            o_sda_oe <= 1'b0;
            i2c_wr_valid <= 1'b0;
            i2c_wr_data <= 16'h0000;
            i2c_gc_reset <= 1'b0;
        end
        else
        begin
            i2c_wr_valid <= 1'b0;
            i2c_gc_reset <= 1'b0;
            if (!i2c_active || i2c_stop)
            begin
                i2c_state <= I2C_IDLE;
                o_sda_oe <= 1'b0;
                ack_phase <= 1'b0;
            end
            else if (i2c_start)
            begin
                i2c_state <= I2C_RX;
                bit_count <= 3'h0;
                byte_index <= 2'h0;
                o_sda_oe <= 1'b0;
                ack_phase <= 1'b0;
            end
            else
            begin
                case (i2c_state)
                    I2C_RX:
                        if (scl_rise)
                        begin
                            rx_byte <= {rx_byte[6:0], i_serial_data_in};
                            bit_count <= bit_count + 3'd1;
                            if (bit_count == 3'd7)
                                i2c_state <= I2C_RX_ACK;
                        end
                    I2C_RX_ACK:
                        if (scl_fall && !ack_phase)
                        begin
                            if (byte_index != 2'd0 || rx_byte == `I2C_GENERAL_CALL_ADDR
                                || rx_byte[7:1] == {I2C_ADDR_BASE[6:1], i_frame_select_n})
                            begin
                                o_sda_oe <= 1'b1;
                                ack_phase <= 1'b1;
                                if (byte_index == 2'd0)
                                begin
                                    is_read <= rx_byte[0];
                                    general_call <= rx_byte == `I2C_GENERAL_CALL_ADDR;
                                end
                            end
                            else
                                i2c_state <= I2C_SKIP;
                        end
                        else if (scl_fall)
                        begin
                            // Fall that ends the acknowledge commits the byte
                            ack_phase <= 1'b0;
                            o_sda_oe <= 1'b0;
                            i2c_state <= I2C_RX;
                            bit_count <= 3'h0;
                            case (byte_index)
                                2'd0:
                                    if (is_read)
                                    begin
                                        i2c_state <= I2C_TX;
                                        o_sda_oe <= ~read_word[15];
                                        tx_word <= {read_word[14:0], 1'b0};
                                        byte_index <= 2'd2;
                                    end
                                    else
                                        byte_index <= 2'd1;
                                2'd1:
                                    if (general_call)
                                    begin
                                        i2c_gc_reset <= rx_byte == `I2C_GENERAL_CALL_RESET;
                                        i2c_state <= I2C_SKIP;
                                    end
                                    else
                                    begin
                                        reg_pointer <= rx_byte;
                                        byte_index <= 2'd2;
                                    end
                                2'd2:
                                begin
                                    data_high_byte <= rx_byte;
                                    byte_index <= 2'd3;
                                end
                                default:
                                begin
                                    i2c_wr_valid <= 1'b1;
                                    i2c_wr_data <= {data_high_byte, rx_byte};
                                    byte_index <= 2'd2;
                                end
                            endcase
                        end
                    I2C_TX:
                        if (scl_rise)
                        begin
                            bit_count <= bit_count + 3'd1;
                            if (bit_count == 3'd7)
                                i2c_state <= I2C_TX_ACK;
                        end
                        else if (scl_fall)
                        begin
                            o_sda_oe <= ~tx_word[15];
                            tx_word <= {tx_word[14:0], 1'b0};
                        end
                    I2C_TX_ACK:
                        if (scl_fall && !ack_phase)
                        begin
                            o_sda_oe <= 1'b0;
                            ack_phase <= 1'b1;
                        end
                        else if (scl_rise && ack_phase)
                            master_ack <= !i_serial_data_in;
                        else if (scl_fall)
                        begin
                            ack_phase <= 1'b0;
                            bit_count <= 3'h0;
                            if (!master_ack)
                                i2c_state <= I2C_SKIP;
                            else if (byte_index == 2'd2)
                            begin
                                i2c_state <= I2C_TX;
                                byte_index <= 2'd3;
                                o_sda_oe <= ~tx_word[15];
                                tx_word <= {tx_word[14:0], 1'b0};
                            end
                            else
                            begin
                                // Further reads repeat the same register
                                i2c_state <= I2C_TX;
                                byte_index <= 2'd2;
                                o_sda_oe <= ~read_word[15];
                                tx_word <= {read_word[14:0], 1'b0};
                            end
                        end
                    I2C_SKIP:
                        o_sda_oe <= 1'b0;
                    I2C_IDLE:
                        o_sda_oe <= 1'b0;
                    default:
                        i2c_state <= I2C_IDLE;
                endcase
            end
        end
    end

    always_comb
    begin
        wr_valid = 1'b0;
        wr_addr = 8'h00;
        wr_data = 16'h0000;
        if (iface_mode == IF_SPI)
        begin
            wr_valid = spi_valid;
            wr_addr = spi_frame[23:16];
            wr_data = spi_frame[15:0];
        end
        else
        begin
            wr_valid = i2c_wr_valid;
            wr_addr = reg_pointer;
            wr_data = i2c_wr_data;
        end
    end

    assign soft_reset_req = i2c_gc_reset
        || (wr_valid && wr_addr == `REG_TRIGGER_AND_RESET && wr_data == `SOFT_RESET_CODE);

    // Registers held at defaults for the whole reset delay
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            deferred_update_enable <= 1'b0;
            buffer_code <= CODE_RESET;
            o_output_code <= CODE_RESET;
            o_output_power_down <= 1'b0;
            o_reference_power_down <= 1'b0;
            o_reference_halve <= `REFERENCE_HALVE_RESET;
            o_output_gain_double <= `OUTPUT_GAIN_DOUBLE_RESET;
        end
        else if (!o_ready)
        begin
            deferred_update_enable <= 1'b0;
            buffer_code <= CODE_RESET;
            o_output_code <= CODE_RESET;
            o_output_power_down <= 1'b0;
            o_reference_power_down <= 1'b0;
            o_reference_halve <= `REFERENCE_HALVE_RESET;
            o_output_gain_double <= `OUTPUT_GAIN_DOUBLE_RESET;
        end
        else if (wr_valid && !soft_reset_req)
        begin
            case (wr_addr)
                `REG_UPDATE_MODE:
                    deferred_update_enable <= wr_data[`BIT_DEFERRED_UPDATE_ENABLE];
                `REG_POWER_DOWN_CONFIG:
                begin
                    o_output_power_down <= wr_data[`BIT_OUTPUT_POWER_DOWN];
                    o_reference_power_down <= wr_data[`BIT_REFERENCE_POWER_DOWN];
                end
                `REG_REFERENCE_AND_GAIN:
                begin
                    o_reference_halve <= wr_data[`BIT_REFERENCE_HALVE];
                    o_output_gain_double <= wr_data[`BIT_OUTPUT_GAIN_DOUBLE];
                end
                `REG_TRIGGER_AND_RESET:
                    if (wr_data[`BIT_LOAD_TRIGGER])
                        o_output_code <= buffer_code;
                `REG_OUTPUT_CODE:
                begin
                    // Low N bits taken as unsigned binary
                    buffer_code <= wr_data[RES_BITS-1:0];
                    if (!deferred_update_enable)
                        o_output_code <= wr_data[RES_BITS-1:0];
                end
                default:
                    buffer_code <= buffer_code;
            endcase
        end
    end

    // Alarm leaves code registers untouched so output returns once fixed
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            o_reference_alarm <= 1'b0;
        else
            o_reference_alarm <= i_reference_overrange && !o_reference_halve;
    end
endmodule

/* hdl/dac_defs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef DAC_DEFS_SVH
`define DAC_DEFS_SVH

`define REG_UPDATE_MODE 8'h02
`define REG_POWER_DOWN_CONFIG 8'h03
`define REG_REFERENCE_AND_GAIN 8'h04
`define REG_TRIGGER_AND_RESET 8'h05
`define REG_OUTPUT_CODE 8'h08

`define BIT_DEFERRED_UPDATE_ENABLE 0
`define BIT_OUTPUT_POWER_DOWN 0
`define BIT_REFERENCE_POWER_DOWN 8
`define BIT_REFERENCE_HALVE 0
`define BIT_OUTPUT_GAIN_DOUBLE 8
`define BIT_LOAD_TRIGGER 4

`define SOFT_RESET_CODE 16'h1010
`define REFERENCE_HALVE_RESET 1'b0
`define OUTPUT_GAIN_DOUBLE_RESET 1'b1

`define CORE_CLK_PERIOD_NS 40
`define POR_DELAY_US 250
`define POR_DELAY_CYCLES ((`POR_DELAY_US * 1000 + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)

`define SPI_FRAME_BITS 5'd24
`define I2C_GENERAL_CALL_ADDR 8'h00
`define I2C_GENERAL_CALL_RESET 8'h06

`endif

/* hdl/dac_pkg.sv */
// Types shared by the converter control logic
package dac_pkg;
    typedef enum {IF_SPI, IF_I2C} iface_type;
    typedef enum {I2C_IDLE, I2C_RX, I2C_RX_ACK, I2C_TX, I2C_TX_ACK, I2C_SKIP} i2c_state_type;
    typedef logic [15:0] reg_word_type;
endpackage

/* hdl/spi_frame_receiver.sv */
// 24-bit SPI frame capture with early-abort handling
`timescale 1ns/1ps
`include "dac_defs.svh"

module spi_frame_receiver
    import dac_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_enable,
    input wire logic i_sclk,
    input wire logic i_serial_data_in,
    input wire logic i_frame_select_n,
    output logic o_frame_valid,
    output logic [23:0] o_frame_data
);
    logic sclk_d;
    logic select_n_d;
    logic [23:0] shift;
    logic [4:0] fall_count;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sclk_d <= 1'b0;
            select_n_d <= 1'b1;
            shift <= 24'h000000;
            fall_count <= 5'h00;
            o_frame_valid <= 1'b0;
            o_frame_data <= 24'h000000;
        end
        else
        begin
            sclk_d <= i_sclk;
            select_n_d <= i_frame_select_n;
            o_frame_valid <= 1'b0;
            if (!i_enable || i_frame_select_n)
            begin
                // Clock and data ignored while deselected; short frames dropped
                shift <= 24'h000000;
                fall_count <= 5'h00;
                if (i_enable && !select_n_d && fall_count == `SPI_FRAME_BITS)
                begin
                    o_frame_valid <= 1'b1;
                    o_frame_data <= shift;
                end
            end
            else if (sclk_d && !i_sclk)
            begin
                // Extra edges keep the last 24 bits
                shift <= {shift[22:0], i_serial_data_in};
                if (fall_count != `SPI_FRAME_BITS)
                    fall_count <= fall_count + 5'd1;
            end
        end
    end
endmodule

/* verif/dac_serial_control_properties.sv */
// Port-level property checker for the converter serial control
`timescale 1ns/1ps
module dac_serial_control_properties #(
    parameter int RES_BITS = 16,
    parameter bit ZERO_SCALE_VARIANT = 1'b1,
    parameter int POR_DELAY_CYCLES = 20
)
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_interface_select_pin,
    input wire logic i_frame_select_n,
    input wire logic i_reference_overrange,
    input wire logic o_sda_oe,
    input wire logic [RES_BITS-1:0] o_output_code,
    input wire logic o_output_power_down,
    input wire logic o_reference_power_down,
    input wire logic o_reference_halve,
    input wire logic o_output_gain_double,
    input wire logic o_reference_alarm,
    input wire logic o_ready
);
    localparam int POR_LO = POR_DELAY_CYCLES - 1;
    localparam int POR_HI = POR_DELAY_CYCLES + 3;
    localparam logic [RES_BITS-1:0] CODE_RESET =
        ZERO_SCALE_VARIANT ? '0 : {1'b1, {(RES_BITS-1){1'b0}}};
    logic [RES_BITS+3:0] regs;
    assign regs = {o_output_code, o_output_power_down, o_reference_power_down,
        o_reference_halve, o_output_gain_double};
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    sequence s_undivided_overrange;
        (i_reference_overrange && !o_reference_halve) [*2];
    endsequence
    // Select pin doubles as an address pin in two-wire mode
    sequence s_deselected;
        (i_frame_select_n && !i_interface_select_pin) [*4] ##0 o_ready;
    endsequence
    a_alarm_raise: assert property (s_undivided_overrange |-> o_reference_alarm)
        else $error("alarm missing");
    a_alarm_clear: assert property (
        (!i_reference_overrange || o_reference_halve) [*2] |-> !o_reference_alarm)
        else $error("alarm without cause");
    a_code_at_frame_end: assert property (
        ($changed(o_output_code) && o_ready && $past(o_ready) && !i_interface_select_pin)
        |-> ($past(i_frame_select_n, 2) && !$past(i_frame_select_n, 3)))
        else $error("code changed outside frame end");
    a_defaults_hold: assert property (
        (!o_ready && !$past(o_ready)) |-> (regs == {CODE_RESET, 4'b0001}))
        else $error("registers not at defaults");
    a_ready_return: assert property (
        $fell(o_ready) |-> ##[POR_LO:POR_HI] o_ready)
        else $error("reset delay wrong");
    a_ready_hold: assert property ($fell(o_ready) |-> !o_ready [*8])
        else $error("reset delay too short");
    a_sda_quiet: assert property (!i_interface_select_pin |-> !o_sda_oe)
        else $error("data line driven in three-wire mode");
    a_deselect_stable: assert property (s_deselected |-> $stable(regs))
        else $error("registers moved while deselected");
endmodule

bind dac_serial_control dac_serial_control_properties #(.RES_BITS(RES_BITS),
    .ZERO_SCALE_VARIANT(ZERO_SCALE_VARIANT), .POR_DELAY_CYCLES(POR_DELAY_CYCLES)) props (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_interface_select_pin(i_interface_select_pin),
    .i_frame_select_n(i_frame_select_n), .i_reference_overrange(i_reference_overrange),
    .o_sda_oe(o_sda_oe), .o_output_code(o_output_code),
    .o_output_power_down(o_output_power_down), .o_reference_power_down(o_reference_power_down),
    .o_reference_halve(o_reference_halve), .o_output_gain_double(o_output_gain_double),
    .o_reference_alarm(o_reference_alarm), .o_ready(o_ready));

/* verif/host_spi_master.sv */
// Behavioural serial host driving the three-wire port
`timescale 1ns/1ps
module host_spi_master
(
    input wire logic i_core_clk,
    output logic o_sclk,
    output logic o_serial_data_in,
    output logic o_frame_select_n
);
    initial
    begin
        o_sclk = 1'b1;
        o_serial_data_in = 1'b0;
        o_frame_select_n = 1'b1;
    end
    // Top nbits of word, MSB first; under 24 bits aborts the frame
    task automatic send(input int nbits, input logic [23:0] word);
        @(posedge i_core_clk);
        o_frame_select_n <= 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            repeat (2) @(posedge i_core_clk);
            o_sclk <= 1'b1;
            o_serial_data_in <= word[23-i];
            repeat (2) @(posedge i_core_clk);
            o_sclk <= 1'b0;
        end
        repeat (2) @(posedge i_core_clk);
        o_frame_select_n <= 1'b1;
        // Inverted idle data, so a stale bit never passes for a good one
        o_serial_data_in <= ~o_serial_data_in;
        o_sclk <= 1'b1;
        repeat (3) @(posedge i_core_clk);
    endtask
    // Two-wire write: start, bytes MSB first with a released ninth bit, stop
    task automatic i2c_send(input int nbytes, input logic [31:0] bytes);
        @(posedge i_core_clk);
        o_serial_data_in <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        o_serial_data_in <= 1'b0;
        for (int i = 0; i < nbytes * 9; i++)
        begin
            repeat (2) @(posedge i_core_clk);
            o_sclk <= 1'b0;
            repeat (2) @(posedge i_core_clk);
            o_serial_data_in <= (i % 9 == 8) ? 1'b1 : bytes[31 - (i / 9) * 8 - i % 9];
            repeat (2) @(posedge i_core_clk);
            o_sclk <= 1'b1;
        end
        // This fall ends the last acknowledge; data low then high is the stop
        repeat (2) @(posedge i_core_clk);
        o_sclk <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        o_serial_data_in <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        o_sclk <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        o_serial_data_in <= 1'b1;
        repeat (3) @(posedge i_core_clk);
    endtask
endmodule

/* verif/tb.sv */
// Self-checking bench for the converter serial control
`timescale 1ns/1ps
`include "dac_defs.svh"
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic overrange = 1'b0;
    logic sclk, serial_data_in, sync_n, sda_out, sda_oe, out_pd, ref_pd, halve, gain, alarm, ready;
    logic sda;
    logic isel = 1'b0;
    logic [15:0] code;
    logic [21:0] st;
    logic [15:0] vals [3] = '{16'hffff, 16'h0001, 16'h8000};
    int mismatches = 0;
    int n_compared = 0;
    assign st = {code, out_pd, ref_pd, halve, gain, alarm, ready};
    // Open-drain data line with pull-up
    assign sda = serial_data_in & ~sda_oe;
    always #20 clk = ~clk;
    host_spi_master host (.i_core_clk(clk), .o_sclk(sclk), .o_serial_data_in(serial_data_in),
        .o_frame_select_n(sync_n));
    // Base 4b with the select pin high answers at 4b, write byte 96
    dac_serial_control #(.POR_DELAY_CYCLES(20), .I2C_ADDR_BASE(7'h4b)) uut (.i_core_clk(clk),
        .i_rst(rst), .i_interface_select_pin(isel), .i_sclk(sclk), .i_serial_data_in(sda),
        .i_frame_select_n(sync_n), .i_reference_overrange(overrange), .o_sda_out(sda_out),
        .o_sda_oe(sda_oe), .o_output_code(code), .o_output_power_down(out_pd),
        .o_reference_power_down(ref_pd), .o_reference_halve(halve),
        .o_output_gain_double(gain), .o_reference_alarm(alarm), .o_ready(ready));
    task automatic conclude();
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [21:0] got, input logic [21:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input int n, input logic [7:0] addr, input logic [15:0] data);
        host.send(n, {addr, data});
        @(negedge clk);
    endtask
    task automatic i2c(input int n, input logic [31:0] bytes);
        host.i2c_send(n, bytes);
        @(negedge clk);
    endtask
    task automatic wait_ready();
        int k;
        k = 0;
        while (ready !== 1'b1 && k < 100)
        begin
            @(negedge clk);
            k++;
        end
        chk(22'(ready), 22'h1);
    endtask
    initial
    begin
        #400000;
        mismatches++;
        conclude();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(st, {16'h0000, 6'b000100});
        repeat (17) @(negedge clk);
        chk(22'(ready), 22'h0);
        wait_ready();
        chk(st, {16'h0000, 6'b000101});
        chk(22'({sda_out, sda_oe}), 22'h0);
        // Taken as a whole frame these 23 bits would load code 1234
        wr(23, 8'h10, 16'h2468);
        chk(st, {16'h0000, 6'b000101});
        foreach (vals[i])
        begin
            wr(24, `REG_OUTPUT_CODE, vals[i]);
            chk(22'(code), 22'(vals[i]));
        end
        wr(24, `REG_POWER_DOWN_CONFIG, 16'h0101);
        chk(22'({out_pd, ref_pd}), 22'h3);
        wr(24, `REG_REFERENCE_AND_GAIN, 16'h0001);
        chk(22'({halve, gain}), 22'h2);
        @(posedge clk);
        overrange <= 1'b1;
        repeat (3) @(negedge clk);
        chk(22'(alarm), 22'h0);
        wr(24, `REG_REFERENCE_AND_GAIN, 16'h0100);
        chk(22'({alarm, code}), 22'h18000);
        @(posedge clk);
        overrange <= 1'b0;
        repeat (3) @(negedge clk);
        chk(22'({alarm, code}), 22'h08000);
        wr(24, `REG_UPDATE_MODE, 16'h0001);
        wr(24, `REG_OUTPUT_CODE, 16'h5a5a);
        chk(22'(code), 22'h8000);
        wr(24, `REG_TRIGGER_AND_RESET, 16'h0010);
        chk(22'(code), 22'h5a5a);
        wr(24, `REG_TRIGGER_AND_RESET, `SOFT_RESET_CODE);
        repeat (2) @(negedge clk);
        chk(st, {16'h0000, 6'b000100});
        wait_ready();
        wr(24, `REG_OUTPUT_CODE, 16'h0042);
        chk(22'(code), 22'h0042);
        // Power up again with the two-wire port selected
        @(posedge clk);
        rst <= 1'b1;
        isel <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wait_ready();
        i2c(4, {8'h96, `REG_OUTPUT_CODE, 16'h3c5a});
        chk(22'(code), 22'h3c5a);
        i2c(2, {`I2C_GENERAL_CALL_ADDR, `I2C_GENERAL_CALL_RESET, 16'h0000});
        chk(st, {16'h0000, 6'b000100});
        wait_ready();
        conclude();
    end
endmodule
